/* File: frcr_top.sv */
// dynamic mode, command and identification registers with fast recovery control
`timescale 1ns/1ps
// What this block does
// - mode field top bits; 00 disables recovery
// - mode 01 holds recovery on continuously
// - mode 10 engages recovery while outputs saturate
// - six-bit threshold, default 3F, limit 2048x
// - saturated over 125ms engages 500ms recovery
// - commands run only with zero payload
// - restart begins at master tick after frame
// - restart returns filters to midscale
// - restart leaves configuration untouched
// - record reset clears interval record memories
// - record reset leaves data path undisturbed
// - read-only identification with alternating pattern
// - identification second nibble holds revision
// - third nibble part, low nibbles serial
// - identification read as first frame after reset returns invalid
// - soft reset restores defaults at frame end
// - mode writes act without restart
module frcr_top #(
	parameter int unsigned SAT_CYCLES  = frcr_pkg::SAT_CYC,  // saturation dwell in clocks
	parameter int unsigned HOLD_CYCLES = frcr_pkg::HOLD_CYC, // recovery hold in clocks
	parameter logic [3:0]  REV_CODE    = 4'h1,    // arbitrary revision value
	parameter logic [3:0]  PART_CODE   = 4'h2,    // arbitrary part value
	parameter logic [11:0] SERIAL_CODE = 12'h000  // arbitrary serial value
) (
	input  logic        sys_clk_i,        // 40 MHz system clock
	input  logic        sys_rst_i,        // asynchronous reset, active high
	input  logic        csb_n_i,          // serial chip select, active low
	input  logic        sclk_i,           // serial clock pin
	input  logic        sdi_i,            // serial data in pin
	input  logic        master_tick_i,    // one-cycle pulse per master timebase edge
	input  logic [17:0] sample_i,         // channel output, two's complement
	output logic        sdo_o,            // serial data out
	output logic        sdo_oe_o,         // serial data out enable
	output logic        fast_recovery_o,  // high-pass bypass engaged
	output logic        restart_o,        // pulse: restart detection, filters to midscale
	output logic        record_clear_o,   // pulse: clear interval record memories
	output logic        soft_reset_o      // pulse: whole-device return to defaults
);
	import frcr_pkg::*;

	// refuse counts that do not fit the counters
	if (SAT_CYCLES < 1 || SAT_CYCLES >= (1 << CNT_W) ||
		HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << CNT_W)) begin : g_bad_cnt
		$error("frcr_top: cycle counts out of range");
	end

	typedef enum logic {
		AUTO_WATCH,
		AUTO_HOLD
	} frcr_auto_t;

	typedef struct packed {
		logic [1:0]       mode;      // recovery mode field
		logic [5:0]       thr;       // recovery threshold field
		frcr_auto_t       auto_st;   // automatic recovery state
		logic [CNT_W-1:0] sat_cnt;   // cycles spent saturated
		logic [CNT_W-1:0] hold_cnt;  // cycles spent holding
		logic             fast;      // recovery output flop
		logic             first_cmd; // no command finished since reset
		logic             rst_pend;  // restart waiting for master tick
		logic             restart;   // restart pulse flop
		logic             rec_clr;   // record clear pulse flop
		logic             swrst;     // soft reset pulse flop
	} frcr_top_st_t;

	localparam frcr_top_st_t ST_RST = '{
		mode:      MODE_RST,
		thr:       THR_RST,
		auto_st:   AUTO_WATCH,
		sat_cnt:   '0,
		hold_cnt:  '0,
		fast:      1'b0,
		first_cmd: 1'b1,
		rst_pend:  1'b0,
		restart:   1'b0,
		rec_clr:   1'b0,
		swrst:     1'b0
	};

	localparam logic [CNT_W-1:0] SAT_LAST  = CNT_W'(SAT_CYCLES);
	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);

	frcr_top_st_t s;       // current state
	frcr_top_st_t next_s;  // next state
	frcr_spi_if   bus ();  // link to the shifter
	logic [17:0]  limit;   // saturation magnitude
	logic         sat;     // sample beyond either limit
	logic         wr_ok;   // write frame finished
	logic         cmd_ok;  // write frame with zero payload

	frcr_spi_shift u_shift (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.csb_n_i   (csb_n_i),
		.sclk_i    (sclk_i),
		.sdi_i     (sdi_i),
		.bus       (bus)
	);

	// read word for the header address; identification masked on a first command
	always_comb begin
		if (bus.hdr_addr == ADDR_DYN_MODE) begin
			bus.rdata = {s.mode, s.thr, 16'h0000};
		end else if (bus.hdr_addr == ADDR_IDENT && !s.first_cmd) begin
			bus.rdata = {ID_PATTERN, REV_CODE, PART_CODE, SERIAL_CODE};
		end else begin
			bus.rdata = 24'h000000;
		end
	end

	// symmetric limits at 2048 times the threshold
	assign limit  = {1'b0, s.thr, 11'h000};
	assign sat    = $signed(sample_i) > $signed(limit) || $signed(sample_i) < -$signed(limit);
	assign wr_ok  = bus.cmd_done && !bus.cmd_rnw;
	assign cmd_ok = wr_ok && bus.cmd_wdata == 24'h000000;

	// register writes, commands and automatic recovery
	always_comb begin
		next_s         = s;
		next_s.restart = 1'b0;
		next_s.rec_clr = 1'b0;
		next_s.swrst   = 1'b0;
		if (bus.cmd_done) begin
			next_s.first_cmd = 1'b0;
		end
		// dynamic mode register takes effect at once
		if (wr_ok && bus.cmd_addr == ADDR_DYN_MODE) begin
			next_s.mode = bus.cmd_wdata[MODE_MSB:MODE_LSB];
			next_s.thr  = bus.cmd_wdata[THR_MSB:THR_LSB];
		end
		// restart waits for the next master edge; configuration stays
		if (s.rst_pend && master_tick_i) begin
			next_s.rst_pend = 1'b0;
			next_s.restart  = 1'b1;
		end
		// a new request in the same cycle as a tick stays pending: set wins
		if (cmd_ok && bus.cmd_addr == ADDR_RESTART) begin
			next_s.rst_pend = 1'b1;
		end
		// record clear only pulses the record memories
		if (cmd_ok && bus.cmd_addr == ADDR_REC_RST) begin
			next_s.rec_clr = 1'b1;
		end
		// automatic recovery sequencing
		if (s.mode != MODE_AUTO) begin
			next_s.auto_st  = AUTO_WATCH;
			next_s.sat_cnt  = '0;
			next_s.hold_cnt = '0;
		end else begin
			case (s.auto_st)
				AUTO_WATCH: begin
					if (!sat) begin
						next_s.sat_cnt = '0;
					end else if (s.sat_cnt == SAT_LAST) begin
						next_s.auto_st = AUTO_HOLD;
						next_s.sat_cnt = '0;
					end else begin
						next_s.sat_cnt = s.sat_cnt + 1'b1;
					end
				end
				AUTO_HOLD: begin
					if (s.hold_cnt == HOLD_LAST) begin
						next_s.auto_st  = AUTO_WATCH;
						next_s.hold_cnt = '0;
					end else begin
						next_s.hold_cnt = s.hold_cnt + 1'b1;
					end
				end
				default: begin
					next_s.auto_st = AUTO_WATCH;
				end
			endcase
		end
		// output from the mode; reserved code acts as normal
		case (next_s.mode)
			MODE_MANUAL: next_s.fast = 1'b1;
			MODE_AUTO:   next_s.fast = next_s.auto_st == AUTO_HOLD;
			default:     next_s.fast = 1'b0;
		endcase
		// soft reset overrides everything at frame end
		if (cmd_ok && bus.cmd_addr == ADDR_SOFT_RST) begin
			next_s       = ST_RST;
			next_s.swrst = 1'b1;
		end
	end

	// state register
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s <= ST_RST;
		end else begin
			s <= next_s;
		end
	end

	assign sdo_o           = bus.sdo;
	assign sdo_oe_o        = bus.sdo_oe;
	assign fast_recovery_o = s.fast;
	assign restart_o       = s.restart;
	assign record_clear_o  = s.rec_clr;
	assign soft_reset_o    = s.swrst;

	// normal or reserved mode never engages recovery
	property p_mode_off;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(s.mode == MODE_NORMAL || s.mode == 2'h3) |-> !s.fast;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("recovery on in normal mode");

	// manual mode keeps recovery on
	property p_manual_on;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		s.mode == MODE_MANUAL |-> s.fast;
	endproperty
	a_manual_on: assert property (p_manual_on) else $error("manual recovery not on");

	// automatic mode output tracks the hold state
	property p_auto_follow;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		s.mode == MODE_AUTO |-> s.fast == (s.auto_st == AUTO_HOLD);
	endproperty
	a_auto_follow: assert property (p_auto_follow) else $error("auto recovery mismatch");

	// hold starts only after the full dwell while saturated
	property p_engage;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		$rose(s.auto_st == AUTO_HOLD) && !$past(bus.cmd_done)
			|-> $past(s.sat_cnt) == SAT_LAST && $past(sat);
	endproperty
	a_engage: assert property (p_engage) else $error("recovery engaged early");

	// hold ends only after its full length
	property p_hold_len;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		$fell(s.auto_st == AUTO_HOLD) && $past(s.mode) == MODE_AUTO && s.mode == MODE_AUTO
			|-> $past(s.hold_cnt) == HOLD_LAST;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("recovery hold cut short");

	// a nonzero payload never fires a command
	property p_nonzero_ignored;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		wr_ok && bus.cmd_wdata != 24'h000000 |=> !s.swrst && !s.rec_clr && !$rose(s.rst_pend);
	endproperty
	a_nonzero_ignored: assert property (p_nonzero_ignored) else $error("bad command ran");

	// restart fires only on a master tick with a pending request
	property p_restart_tick;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		s.restart |-> $past(master_tick_i) && $past(s.rst_pend);
	endproperty
	a_restart_tick: assert property (p_restart_tick) else $error("restart off tick");

	// restart leaves the configuration unchanged
	property p_restart_keeps;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		s.restart && !$past(bus.cmd_done) |-> $stable(s.mode) && $stable(s.thr);
	endproperty
	a_restart_keeps: assert property (p_restart_keeps) else $error("restart changed config");

	// soft reset restores the defaults
	property p_soft_reset;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		cmd_ok && bus.cmd_addr == ADDR_SOFT_RST
			|=> s.mode == MODE_RST && s.thr == THR_RST && s.first_cmd ##1 !s.swrst;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

	// identification is masked until a command has finished
	property p_first_read;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		s.first_cmd && bus.hdr_addr == ADDR_IDENT |-> bus.rdata == 24'h000000;
	endproperty
	a_first_read: assert property (p_first_read) else $error("first id read valid");

	// record clear fires only from a zero-payload record reset write
	property p_rec_clr_cmd;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		s.rec_clr |-> $past(cmd_ok) && $past(bus.cmd_addr) == ADDR_REC_RST;
	endproperty
	a_rec_clr_cmd: assert property (p_rec_clr_cmd) else $error("stray record clear");

	// record clear leaves the configuration alone
	property p_rec_clr_keeps;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		s.rec_clr |-> $stable(s.mode) && $stable(s.thr);
	endproperty
	a_rec_clr_keeps: assert property (p_rec_clr_keeps) else $error("record clear disturbed");

	// soft reset pulse comes only from a zero-payload soft reset write
	property p_swrst_cmd;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		s.swrst |-> $past(cmd_ok) && $past(bus.cmd_addr) == ADDR_SOFT_RST;
	endproperty
	a_swrst_cmd: assert property (p_swrst_cmd) else $error("stray soft reset");

	// an accepted restart request is always left pending
	property p_pend_set;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		cmd_ok && bus.cmd_addr == ADDR_RESTART |=> s.rst_pend;
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("restart request lost");

	// the dwell count starts over whenever the output is back inside
	property p_sat_clear;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		s.mode == MODE_AUTO && s.auto_st == AUTO_WATCH && !sat |=> s.sat_cnt == '0;
	endproperty
	a_sat_clear: assert property (p_sat_clear) else $error("dwell not restarted");
endmodule : frcr_top

/* File: frcr_pkg.sv */
// shared constants for the fast recovery and command register block
package frcr_pkg;
	// register addresses on the 7-bit serial address field
	localparam logic [6:0]  ADDR_DYN_MODE   = 7'h05;
	localparam logic [6:0]  ADDR_SOFT_RST   = 7'h08;
	localparam logic [6:0]  ADDR_RESTART    = 7'h09;
	localparam logic [6:0]  ADDR_REC_RST    = 7'h0A;
	localparam logic [6:0]  ADDR_IDENT      = 7'h0F;
	// field positions inside the 24-bit data word
	localparam int          MODE_MSB        = 23;
	localparam int          MODE_LSB        = 22;
	localparam int          THR_MSB         = 21;
	localparam int          THR_LSB         = 16;
	// recovery mode encodings
	localparam logic [1:0]  MODE_NORMAL     = 2'h0;
	localparam logic [1:0]  MODE_MANUAL     = 2'h1;
	localparam logic [1:0]  MODE_AUTO       = 2'h2;
	// reset values
	localparam logic [1:0]  MODE_RST        = 2'h0;
	localparam logic [5:0]  THR_RST         = 6'h3F;
	// threshold scale: limit is threshold shifted left by this many bits
	localparam int          THR_SHIFT       = 11;
	// identification word layout
	localparam logic [3:0]  ID_PATTERN      = 4'h5;
	// serial frame layout
	localparam logic [5:0]  FRAME_BITS      = 6'h20;
	localparam logic [5:0]  HDR_BITS        = 6'h08;
	// timing
	localparam int          CLK_HZ          = 40_000_000;
	localparam int          SAT_TIME_MS     = 125;
	localparam int          HOLD_TIME_MS    = 500;
	localparam int          SAT_CYC         = SAT_TIME_MS * (CLK_HZ / 1000);
	localparam int          HOLD_CYC        = HOLD_TIME_MS * (CLK_HZ / 1000);
	localparam int          CNT_W           = 25;
endpackage : frcr_pkg

/* File: frcr_spi_if.sv */
// carrier between the serial shifter and the register logic
`timescale 1ns/1ps
interface frcr_spi_if;
	logic [6:0]  cmd_addr;   // address of the finished frame
	logic        cmd_rnw;    // 1 = read frame
	logic [23:0] cmd_wdata;  // payload of the finished frame
	logic        cmd_done;   // one-cycle pulse after the 32nd rising edge
	logic [6:0]  hdr_addr;   // address once the header is in
	logic [23:0] rdata;      // read word for hdr_addr
	logic        sdo;        // serial data out
	logic        sdo_oe;     // serial data out enable
	modport shifter (output cmd_addr, cmd_rnw, cmd_wdata, cmd_done, hdr_addr, sdo, sdo_oe,
		input rdata);
	modport regs (input cmd_addr, cmd_rnw, cmd_wdata, cmd_done, hdr_addr, sdo, sdo_oe,
		output rdata);
endinterface : frcr_spi_if

/* File: frcr_spi_shift.sv */
// 32-clock serial frame shifter with pin synchronisers
`timescale 1ns/1ps
module frcr_spi_shift (
	input  logic       sys_clk_i,
	input  logic       sys_rst_i,
	input  logic       csb_n_i,
	input  logic       sclk_i,
	input  logic       sdi_i,
	frcr_spi_if.shifter bus
);
	import frcr_pkg::*;

	typedef struct packed {
		logic [1:0]  csb_n;   // two-stage synchroniser
		logic [1:0]  sclk;    // two-stage synchroniser
		logic        sclk_d;  // previous synchronised clock
		logic [1:0]  sdi;     // two-stage synchroniser
		logic [5:0]  cnt;     // rising edges seen in this frame
		logic [31:0] sh;      // incoming shift register
		logic [31:0] cap;     // captured finished frame
		logic        done;    // frame finished pulse
		logic [23:0] rd;      // outgoing shift register
		logic        sdo;     // output data flop
		logic        oe;      // output enable flop
	} frcr_shift_st_t;

	frcr_shift_st_t s;      // current state
	frcr_shift_st_t next_s; // next state

	// frame decode and shifting
	always_comb begin
		next_s          = s;
		next_s.done     = 1'b0;
		next_s.csb_n[0] = csb_n_i;
		next_s.csb_n[1] = s.csb_n[0];
		next_s.sclk[0]  = sclk_i;
		next_s.sclk[1]  = s.sclk[0];
		next_s.sclk_d   = s.sclk[1];
		next_s.sdi[0]   = sdi_i;
		next_s.sdi[1]   = s.sdi[0];
		if (s.csb_n[1]) begin
			// deselected: restart frame, release the line
			next_s.cnt = 6'h00;
			next_s.oe  = 1'b0;
			next_s.sdo = 1'b0;
		end else begin
			next_s.oe = 1'b1;
			// rising edge: sample data in
			if (s.sclk[1] && !s.sclk_d && s.cnt < FRAME_BITS) begin
				next_s.sh  = {s.sh[30:0], s.sdi[1]};
				next_s.cnt = s.cnt + 6'h01;
				if (s.cnt == FRAME_BITS - 6'h01) begin
					next_s.done = 1'b1;
					next_s.cap  = {s.sh[30:0], s.sdi[1]};
				end
			end
			// falling edge: shift data out after the header
			if (!s.sclk[1] && s.sclk_d && s.cnt >= HDR_BITS && s.cnt < FRAME_BITS) begin
				if (s.cnt == HDR_BITS) begin
					next_s.sdo = bus.rdata[23];
					next_s.rd  = {bus.rdata[22:0], 1'b0};
				end else begin
					next_s.sdo = s.rd[23];
					next_s.rd  = {s.rd[22:0], 1'b0};
				end
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s       <= '0;
			s.csb_n <= 2'h3;
		end else begin
			s <= next_s;
		end
	end

	assign bus.cmd_addr  = s.cap[31:25];
	assign bus.cmd_rnw   = s.cap[24];
	assign bus.cmd_wdata = s.cap[23:0];
	assign bus.cmd_done  = s.done;
	assign bus.hdr_addr  = s.sh[7:1];
	assign bus.sdo       = s.sdo;
	assign bus.sdo_oe    = s.oe;

	// a frame ends only after exactly 32 rising edges
	property p_done_at_32;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		s.done |-> $past(s.cnt) == FRAME_BITS - 6'h01 && s.cnt == FRAME_BITS;
	endproperty
	a_done_at_32: assert property (p_done_at_32) else $error("frame end not at 32nd edge");
endmodule : frcr_spi_shift

/* File: frcr_host_model.sv */
// serial host model that frames 32-clock transactions into the register block
`timescale 1ns/1ps
module frcr_host_model #(
	parameter int PH = 8  // sys clocks per serial clock phase
) (
	input  wire logic sys_clk_i,  // system clock
	input  wire logic sdo_i,      // serial data from device
	input  wire logic sdo_oe_i,   // device drive enable
	output logic      csb_n_o,    // chip select, active low
	output logic      sclk_o,     // serial clock, idle low
	output logic      sdi_o       // serial data to device
);
	// idle: deselected, clock parked low
	initial begin
		csb_n_o = 1'b1;
		sclk_o  = 1'b0;
		sdi_o   = 1'b0;
	end

	// wait n edges, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#2;
	endtask : tick

	// one frame: address msb first, read flag, 24 data bits msb first
	task automatic xfer(input logic [6:0] a, input logic rnw, input logic [23:0] wd,
		output logic [23:0] rd);
		logic [31:0] fr;
		fr = {a, rnw, wd};
		rd = 24'h000000;
		tick(1);
		csb_n_o = 1'b0;
		for (int i = 0; i < 32; i++) begin
			sdi_o = fr[31-i];
			tick(PH);
			// read bits appear after falling edges 8..31
			// an undriven line reads as the inverse, so a missing enable shows
			if (i >= 8)
				rd = {rd[22:0], sdo_oe_i ? sdo_i : ~sdo_i};
			sclk_o = 1'b1;
			tick(PH);
			sclk_o = 1'b0;
		end
		tick(PH);
		csb_n_o = 1'b1;
		// released data line shows the inverse, never a stale level
		sdi_o = ~sdi_o;
		tick(PH);
	endtask : xfer
endmodule : frcr_host_model

/* File: frcr_tb_top.sv */
// self-checking bench of the register block against a behavioural host
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module frcr_tb_top;
	import frcr_pkg::*;
	localparam int SAT  = 20;  // shortened dwell
	localparam int HOLD = 50;  // shortened hold
	localparam logic [3:0]  REV_V   = 4'h1;     // arbitrary revision value
	localparam logic [3:0]  PART_V  = 4'h2;     // arbitrary part value
	localparam logic [11:0] SER_V   = 12'h000;  // arbitrary serial value
	localparam logic [23:0] ID_WORD = {ID_PATTERN, REV_V, PART_V, SER_V};
	localparam int          WD_CYC  = 50 * 600; // about 25 frames of ~530 cycles, doubled
	logic        sys_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        master_tick_i = 1'b0;
	logic [17:0] sample_i = 18'h00000;
	logic [17:0] samp_val = 18'h00000;  // directed sample value
	logic        samp_rnd = 1'b1;       // random samples when set
	logic [31:0] lfsr = 32'hB73B;
	wire         csb_n, sclk, sdi, sdo, sdo_oe;
	wire         fast, restart, rclr, srst;
	int          num_errors = 0;
	int          tests_run = 0;
	int          cnt_soft = 0, cnt_rst = 0, cnt_clr = 0, bad_tick = 0;
	int          e_soft = 0, e_rst = 0, e_clr = 0;  // model pulse counts
	logic [1:0]  tick_h = 2'b00;
	logic [23:0] v;
	logic [5:0]  th;
	int          n, lim;

	frcr_top #(.SAT_CYCLES(SAT), .HOLD_CYCLES(HOLD), .REV_CODE(REV_V), .PART_CODE(PART_V),
		.SERIAL_CODE(SER_V)) frcr_top_inst (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .csb_n_i(csb_n), .sclk_i(sclk),
		.sdi_i(sdi), .master_tick_i(master_tick_i), .sample_i(sample_i), .sdo_o(sdo),
		.sdo_oe_o(sdo_oe), .fast_recovery_o(fast), .restart_o(restart),
		.record_clear_o(rclr), .soft_reset_o(srst));
	frcr_host_model frcr_host_model_inst (.sys_clk_i(sys_clk_i), .sdo_i(sdo),
		.sdo_oe_i(sdo_oe), .csb_n_o(csb_n), .sclk_o(sclk), .sdi_o(sdi));

	// clock generator
	always #12.5 sys_clk_i = ~sys_clk_i;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	// random timebase ticks and samples, just after each edge
	always @(posedge sys_clk_i) begin
		#2;
		lfsr = lfsr_next(lfsr);
		master_tick_i = (lfsr[7:5] == 3'h0);
		sample_i = samp_rnd ? lfsr[17:0] : samp_val;
	end

	// pulse counting; restart must follow a timebase tick
	always @(negedge sys_clk_i) begin
		if (srst === 1'b1) cnt_soft++;
		if (rclr === 1'b1) cnt_clr++;
		if (restart === 1'b1) begin
			cnt_rst++;
			if (tick_h == 2'b00) bad_tick++;
		end
		tick_h = {tick_h[0], master_tick_i};
	end

	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk_i);
		#2;
	endtask : tick

	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		logic [23:0] dummy;
		frcr_host_model_inst.xfer(a, 1'b0, d, dummy);
	endtask : wr

	task automatic rd(input logic [6:0] a, output logic [23:0] d);
		frcr_host_model_inst.xfer(a, 1'b1, 24'h000000, d);
	endtask : rd

	// command write; only an all-zero payload may act
	task automatic cmd(input logic [6:0] a, input logic [23:0] d);
		wr(a, d);
		tick(60);
		if (d == 24'h000000) begin
			if (a == ADDR_SOFT_RST) e_soft++;
			if (a == ADDR_RESTART) e_rst++;
			if (a == ADDR_REC_RST) e_clr++;
		end
		`CHK(cnt_soft, e_soft)
		`CHK(cnt_rst, e_rst)
		`CHK(cnt_clr, e_clr)
	endtask : cmd

	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// watchdog
	initial begin
		repeat (WD_CYC) @(posedge sys_clk_i);
		num_errors++;
		report_and_stop();
	end

	// main sequence
	initial begin
		repeat (6) @(posedge sys_clk_i);
		#2;
		sys_rst_i = 1'b0;
		tick(4);
		rd(ADDR_IDENT, v);
		`CHK(v, 24'h000000)
		rd(ADDR_DYN_MODE, v);
		`CHK(v, {2'b00, 6'h3F, 16'h0000})
		rd(ADDR_IDENT, v);
		`CHK(v, ID_WORD)
		wr(ADDR_IDENT, lfsr[23:0]);
		rd(ADDR_IDENT, v);
		`CHK(v, ID_WORD)
		rd(7'h03, v);
		`CHK(v, 24'h000000)
		$display("test identification finished");
		// every mode code, acting at once without restart
		// code 11 here is a deliberate breach, to exercise the reserved-code guard
		for (int m = 0; m < 4; m++) begin
			th = lfsr[13:8];
			wr(ADDR_DYN_MODE, {2'(m), th, lfsr[15:0]});
			tick(4);
			`CHK(fast, 1'(m == 1))
			rd(ADDR_DYN_MODE, v);
			`CHK(v, {2'(m), th, 16'h0000})
		end
		$display("test modes finished");
		// automatic recovery with dwell and hold
		samp_rnd = 1'b0;
		samp_val = 18'h00000;
		th = lfsr[5:0] | 6'h01;
		lim = int'(th) * 2048;
		wr(ADDR_DYN_MODE, {MODE_AUTO, th, 16'h0000});
		samp_val = 18'(lim);
		n = 0;
		repeat (3 * SAT) begin
			tick(1);
			if (fast === 1'b1) n++;
		end
		`CHK(n, 0)
		samp_val = lfsr[0] ? 18'(lim + 1) : 18'(-(lim + 1));
		n = 0;
		while (fast !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		`CHK(1'(n >= SAT + 1 && n <= SAT + 5), 1'b1)
		samp_val = 18'h00000;
		n = 0;
		while (fast === 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		`CHK(n, HOLD)
		tick(3 * SAT);
		`CHK(fast, 1'b0)
		$display("test automatic recovery finished");
		// commands: refused payloads, then executed ones
		samp_rnd = 1'b1;
		th = lfsr[21:16];
		wr(ADDR_DYN_MODE, {MODE_MANUAL, th, 16'h0000});
		cmd(ADDR_REC_RST, lfsr[23:0] | 24'h000100);
		cmd(ADDR_REC_RST, 24'h000000);
		`CHK(fast, 1'b1)
		cmd(ADDR_RESTART, lfsr[23:0] | 24'h800000);
		// mode configured first; no general setting changed, so no lock wait
		cmd(ADDR_RESTART, 24'h000000);
		`CHK(bad_tick, 0)
		rd(ADDR_DYN_MODE, v);
		`CHK(v, {MODE_MANUAL, th, 16'h0000})
		cmd(ADDR_SOFT_RST, lfsr[23:0] | 24'h000001);
		`CHK(fast, 1'b1)
		cmd(ADDR_SOFT_RST, 24'h000000);
		`CHK(fast, 1'b0)
		rd(ADDR_IDENT, v);
		`CHK(v, 24'h000000)
		rd(ADDR_DYN_MODE, v);
		`CHK(v, {2'b00, 6'h3F, 16'h0000})
		$display("test commands finished");
		report_and_stop();
	end
endmodule : frcr_tb_top
